// [hw/ovsw_pkg.sv]
package ovsw_pkg;

    // register offsets
    localparam logic [7:0] OVSW_ADDR_IDENT  = 8'h00;
    localparam logic [7:0] OVSW_ADDR_CTRL   = 8'h01;
    localparam logic [7:0] OVSW_ADDR_STATUS = 8'h02;
    localparam logic [7:0] OVSW_ADDR_FLAGS  = 8'h03;
    localparam logic [7:0] OVSW_ADDR_MASK   = 8'h04;

    // field positions
    localparam int OVSW_BIT_SW_DIS   = 7;
    localparam int OVSW_BIT_DETECTION_ENABLE   = 6;
    localparam int OVSW_BIT_PON      = 7;
    localparam int OVSW_BIT_TAG      = 6;
    localparam int OVSW_BIT_TMO      = 5;
    localparam int OVSW_BIT_SW_ON    = 4;
    localparam int OVSW_BIT_OV       = 2;
    localparam int OVSW_BIT_HS       = 1;
    localparam int OVSW_BIT_OT       = 0;
    localparam logic [1:0] OVSW_CTRL_ILLEGAL = 2'h1;

    // reset values
    localparam logic [1:0] OVSW_CTRL_RST = 2'h0;
    localparam logic [3:0] OVSW_STAT_RST = 4'h0;
    localparam logic [2:0] OVSW_FLAG_RST = 3'h0;
    localparam logic [7:0] OVSW_MASK_RST = 8'h00;
    localparam logic [7:0] OVSW_MASK_USED = 8'hF7;

    // identification values are arbitrary
    localparam logic [4:0] OVSW_VENDOR_CODE   = 5'h1A;
    localparam logic [2:0] OVSW_REVISION_CODE = 3'h5;

    // timing
    localparam int OVSW_CLK_PERIOD_NS       = 10;
    localparam int OVSW_DEBOUNCE_TIME_US    = 15;
    localparam int OVSW_SHORT_RESTART_US    = 100;
    localparam int OVSW_INT_TIMEOUT_US      = 1000;
    localparam int OVSW_DEBOUNCE_CYC =
        (OVSW_DEBOUNCE_TIME_US * 1000 + OVSW_CLK_PERIOD_NS - 1) / OVSW_CLK_PERIOD_NS;
    localparam int OVSW_SHORT_RESTART_CYC =
        (OVSW_SHORT_RESTART_US * 1000 + OVSW_CLK_PERIOD_NS - 1) / OVSW_CLK_PERIOD_NS;
    localparam int OVSW_INT_TIMEOUT_CYC =
        (OVSW_INT_TIMEOUT_US * 1000) / OVSW_CLK_PERIOD_NS;
    localparam int OVSW_CNT_W = 20;

    // power switch states, gray along off -> debounce -> on -> short wait
    typedef enum logic [1:0] {
        OVSW_SW_OFF  = 2'h0,
        OVSW_SW_DEB  = 2'h1,
        OVSW_SW_ON   = 2'h3,
        OVSW_SW_HSW  = 2'h2
    } ovsw_sw_state_t;

endpackage

// [hw/ovsw_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ovsw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] hold_r;

    // two stages; only the second stage is visible outside
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            hold_r <= '0;
        end else begin
            meta_r <= async_in;
            hold_r <= meta_r;
        end
    end

    assign sync_out = hold_r;
endmodule
`default_nettype wire

// [hw/ovsw_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module ovsw_regs
    import ovsw_pkg::*;
#(
    parameter int DEB_CYCLES = OVSW_DEBOUNCE_CYC,
    parameter int HS_CYCLES  = OVSW_SHORT_RESTART_CYC,
    parameter int ITO_CYCLES = OVSW_INT_TIMEOUT_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       chip_enable_n,
    input  wire logic       vin_above_uv_rise,
    input  wire logic       vin_below_uv_fall,
    input  wire logic       vin_over_ov,
    input  wire logic       out_hard_short,
    input  wire logic       die_over_temp,
    input  wire logic       det_period,
    input  wire logic [7:0] adc_result,
    input  wire logic [7:0] adc_threshold,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            switch_gate_on,
    output logic            test_current_en,
    output logic            adc_run,
    output logic            interrupt_n_o,
    output logic            interrupt_n_oe
);
    localparam logic [OVSW_CNT_W-1:0] DEB_LAST = OVSW_CNT_W'(DEB_CYCLES - 1);
    localparam logic [OVSW_CNT_W-1:0] HS_LAST  = OVSW_CNT_W'(HS_CYCLES - 1);
    localparam logic [OVSW_CNT_W-1:0] ITO_LAST = OVSW_CNT_W'(ITO_CYCLES - 1);

    // analog comparator levels come from another domain
    logic [5:0] sync_v;
    logic       enb_n_s;
    logic       uv_rise_s;
    logic       uv_fall_s;
    logic       ov_s;
    logic       hs_s;
    logic       ot_s;

    ovsw_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({chip_enable_n, vin_above_uv_rise, vin_below_uv_fall,
                    vin_over_ov, out_hard_short, die_over_temp}),
        .sync_out (sync_v)
    );
    assign {enb_n_s, uv_rise_s, uv_fall_s, ov_s, hs_s, ot_s} = sync_v;

    logic [1:0]             ctrl_r;
    logic [1:0]             ctrl_nxt;
    logic [3:0]             stat_r;
    logic [3:0]             stat_nxt;
    logic [2:0]             flag_r;
    logic [2:0]             flag_nxt;
    logic [7:0]             mask_r;
    logic [7:0]             mask_nxt;
    logic [7:0]             pend_r;
    logic [7:0]             pend_nxt;
    logic [7:0]             rdata_r;
    logic [7:0]             rdata_nxt;
    logic                   irq_r;
    logic                   irq_nxt;
    logic                   det_run_r;
    logic                   det_run_nxt;
    logic                   det_prd_r;
    logic [OVSW_CNT_W-1:0]  ito_cnt_r;
    logic [OVSW_CNT_W-1:0]  ito_cnt_nxt;
    ovsw_sw_state_t         sw_r;
    ovsw_sw_state_t         sw_nxt;
    logic [OVSW_CNT_W-1:0]  sw_cnt_r;
    logic [OVSW_CNT_W-1:0]  sw_cnt_nxt;

    logic       enabled;
    logic       sw_mode;
    logic       det_active;
    logic       stress;
    logic       pon_rise;
    logic       rd_status;
    logic       rd_flags;
    logic       ito_hit;
    logic       det_start;
    logic       release_int;
    logic [2:0] flag_set;
    logic [2:0] flag_kept;
    logic [7:0] events;

    assign enabled   = !enb_n_s;
    assign sw_mode   = enabled && !ctrl_r[1];
    assign rd_status = reg_rd && (reg_addr == OVSW_ADDR_STATUS);
    assign rd_flags  = reg_rd && (reg_addr == OVSW_ADDR_FLAGS);
    assign pon_rise  = enabled && uv_rise_s && !stat_r[3];
    assign det_start = ctrl_r[0] && det_period && !det_prd_r;
    assign ito_hit   = irq_r && (ito_cnt_r == ITO_LAST);
    // the converter runs only while the input sits below the falling uv level
    assign det_active = enabled && ctrl_r[0] && uv_fall_s && det_period;
    // any stress keeps or forces the transistor off
    assign stress = !uv_rise_s || ov_s || hs_s || ot_s || det_active;

    // control register: illegal code dropped, power-up restores defaults
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (pon_rise) begin
            ctrl_nxt = OVSW_CTRL_RST;
        end else if (reg_wr && reg_addr == OVSW_ADDR_CTRL &&
                     reg_wdata[7:6] != OVSW_CTRL_ILLEGAL) begin
            ctrl_nxt = reg_wdata[7:6];
        end
        mask_nxt = mask_r;
        if (reg_wr && reg_addr == OVSW_ADDR_MASK) begin
            mask_nxt = reg_wdata & OVSW_MASK_USED;  // reserved bit reads zero
        end
    end

    // switch sequencer: debounce before turn-on, hold off after a short
    always_comb begin
        sw_nxt     = sw_r;
        sw_cnt_nxt = sw_cnt_r;
        case (sw_r)
            OVSW_SW_OFF: begin
                sw_cnt_nxt = '0;
                if (sw_mode && hs_s) begin
                    sw_nxt = OVSW_SW_HSW;
                end else if (sw_mode && !stress) begin
                    sw_nxt = OVSW_SW_DEB;
                end
            end
            OVSW_SW_DEB: begin
                sw_cnt_nxt = sw_cnt_r + 1'b1;
                if (sw_mode && hs_s) begin
                    sw_nxt     = OVSW_SW_HSW;
                    sw_cnt_nxt = '0;
                end else if (!sw_mode || stress) begin
                    sw_nxt = OVSW_SW_OFF;
                end else if (sw_cnt_r == DEB_LAST) begin
                    sw_nxt = OVSW_SW_ON;
                end
            end
            OVSW_SW_ON: begin
                sw_cnt_nxt = '0;
                if (sw_mode && hs_s) begin
                    sw_nxt = OVSW_SW_HSW;
                end else if (!sw_mode || stress) begin
                    sw_nxt = OVSW_SW_OFF;
                end
            end
            OVSW_SW_HSW: begin
                // held off even if the flag was read meanwhile
                sw_cnt_nxt = sw_cnt_r + 1'b1;
                if (sw_cnt_r == HS_LAST) begin
                    sw_nxt = OVSW_SW_OFF;
                end
            end
            default: begin
                sw_nxt     = OVSW_SW_OFF;
                sw_cnt_nxt = '0;
            end
        endcase
    end

    // status bits; detection bits freeze while detection is disabled
    always_comb begin
        stat_nxt = stat_r;
        if (enabled && uv_rise_s) begin
            stat_nxt[3] = 1'b1;
        end else if (uv_fall_s || !enabled) begin
            stat_nxt[3] = 1'b0;
        end
        if (ctrl_r[0]) begin
            if (adc_result > adc_threshold) begin
                stat_nxt[2] = 1'b1;
            end else if (adc_result < adc_threshold) begin
                stat_nxt[2] = 1'b0;
            end
            stat_nxt[1] = !det_period;
        end
        stat_nxt[0] = (sw_r == OVSW_SW_ON);
        det_run_nxt = det_active;
    end

    // protection flags: a set in the clearing cycle wins over the read
    always_comb begin
        flag_set  = sw_mode ? {ov_s, hs_s, ot_s} : 3'h0;
        flag_kept = rd_flags ? 3'h0 : flag_r;
        flag_nxt  = flag_kept | flag_set;
    end

    // pending interrupt events, one per status or flag bit
    always_comb begin
        events = 8'h00;
        if (enabled) begin
            events[OVSW_BIT_PON]   = pon_rise;
            events[OVSW_BIT_TAG]   = stat_nxt[2] && !stat_r[2];
            events[OVSW_BIT_TMO]   = stat_nxt[1] && !stat_r[1];
            events[OVSW_BIT_SW_ON] = stat_nxt[0] && !stat_r[0];
            events[2:0]            = flag_set & ~flag_kept;
        end
        release_int = rd_status || rd_flags || ito_hit || det_start ||
                      (uv_fall_s && stat_r[3]) || !enabled;
        pend_nxt = (release_int ? 8'h00 : pend_r) | events;
        irq_nxt  = |(pend_r & ~mask_r);
        ito_cnt_nxt = irq_r ? ((ito_cnt_r == ITO_LAST) ? '0 : ito_cnt_r + 1'b1) : '0;
    end

    // read data: value before any clear, reserved bits zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                OVSW_ADDR_IDENT:  rdata_nxt = {OVSW_VENDOR_CODE, OVSW_REVISION_CODE};
                OVSW_ADDR_CTRL:   rdata_nxt = {ctrl_r, 6'h00};
                OVSW_ADDR_STATUS: rdata_nxt = {stat_r, 4'h0};
                OVSW_ADDR_FLAGS:  rdata_nxt = {5'h00, flag_r};
                OVSW_ADDR_MASK:   rdata_nxt = mask_r;
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r    <= OVSW_CTRL_RST;
            mask_r    <= OVSW_MASK_RST;
            stat_r    <= OVSW_STAT_RST;
            flag_r    <= OVSW_FLAG_RST;
            pend_r    <= 8'h00;
            irq_r     <= 1'b0;
            ito_cnt_r <= '0;
            rdata_r   <= 8'h00;
            det_run_r <= 1'b0;
            det_prd_r <= 1'b0;
            sw_r      <= OVSW_SW_OFF;
            sw_cnt_r  <= '0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            mask_r    <= mask_nxt;
            stat_r    <= stat_nxt;
            flag_r    <= flag_nxt;
            pend_r    <= pend_nxt;
            irq_r     <= irq_nxt;
            ito_cnt_r <= ito_cnt_nxt;
            rdata_r   <= rdata_nxt;
            det_run_r <= det_run_nxt;
            det_prd_r <= det_period;
            sw_r      <= sw_nxt;
            sw_cnt_r  <= sw_cnt_nxt;
        end
    end

    // open drain: only ever pulls low, never drives high
    assign interrupt_n_o   = 1'b0;
    assign interrupt_n_oe  = irq_r;
    assign reg_rdata       = rdata_r;
    assign switch_gate_on  = stat_r[0];
    assign test_current_en = det_run_r;
    assign adc_run         = det_run_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_ident_read;
        reg_rd && reg_addr == OVSW_ADDR_IDENT |=> reg_rdata == {OVSW_VENDOR_CODE, OVSW_REVISION_CODE};
    endproperty
    a_ident_read: assert property (p_ident_read) else $error("identification read wrong");

    property p_illegal_ctrl;
        reg_wr && reg_addr == OVSW_ADDR_CTRL && reg_wdata[7:6] == OVSW_CTRL_ILLEGAL && !pon_rise
            |=> ctrl_r == $past(ctrl_r);
    endproperty
    a_illegal_ctrl: assert property (p_illegal_ctrl) else $error("illegal control code accepted");

    property p_disable_off;
        ctrl_r[1] |=> ##1 !switch_gate_on;
    endproperty
    a_disable_off: assert property (p_disable_off) else $error("switch on while disabled");

    property p_debounce;
        $rose(switch_gate_on) |-> $past(sw_r, 2) == OVSW_SW_DEB && $past(sw_cnt_r, 2) == DEB_LAST;
    endproperty
    a_debounce: assert property (p_debounce) else $error("turn-on without full debounce");

    property p_stress_off;
        sw_r == OVSW_SW_ON && stress |=> sw_r != OVSW_SW_ON;
    endproperty
    a_stress_off: assert property (p_stress_off) else $error("switch stays on under stress");

    property p_det_window;
        test_current_en |-> $past(ctrl_r[0] && uv_fall_s && det_period && enabled);
    endproperty
    a_det_window: assert property (p_det_window) else $error("test current outside window");

    property p_ov_flag;
        sw_mode && ov_s |=> flag_r[OVSW_BIT_OV] ##1 !switch_gate_on;
    endproperty
    a_ov_flag: assert property (p_ov_flag) else $error("overvoltage not latched");

    property p_flag_clear;
        rd_flags && !(sw_mode && (ov_s || hs_s || ot_s)) |=> flag_r == 3'h0;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag read did not clear");

    property p_mask_all;
        (mask_r == OVSW_MASK_USED) && !pend_r[3] |=> !interrupt_n_oe;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("masked event drove interrupt");

    property p_hs_hold;
        $rose(sw_r == OVSW_SW_HSW) |=> (!switch_gate_on)[*8];
    endproperty
    a_hs_hold: assert property (p_hs_hold) else $error("switch on during short restart");

    property p_sw_event;
        $rose(switch_gate_on) && enabled |-> pend_r[OVSW_BIT_SW_ON];
    endproperty
    a_sw_event: assert property (p_sw_event) else $error("turn-on event not pending");
endmodule
`default_nettype wire

// [verification/ovsw_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ovsw_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       interrupt_n_o,
    input  wire logic       interrupt_n_oe,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output wire logic       int_line
);
    // host pull-up: a released line reads high, never the last driven level
    assign int_line = interrupt_n_oe ? interrupt_n_o : 1'b1;

    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write strobe; stale data is inverted so nothing relies on it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // read data is taken a full cycle after the strobe, where it stands settled
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [verification/ovsw_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ovsw_regs_tb_top
    import ovsw_pkg::*;
;
    logic       clk;
    logic       sys_rst;
    logic       chip_enable_n;
    logic       above;
    logic       below;
    logic       ov;
    logic       hs;
    logic       ot;
    logic       det_period;
    logic [7:0] adc_result;
    logic [7:0] adc_threshold;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       gate;
    logic       tce;
    logic       adc_run;
    logic       int_o;
    logic       int_oe;
    wire        int_line;
    int         failures;
    int         num_checks;
    int         cyc;

    // short counts keep the run brief; expectations follow these values
    ovsw_regs #(.DEB_CYCLES(4), .HS_CYCLES(6), .ITO_CYCLES(400)) DUT (
        .clk(clk), .sys_rst(sys_rst), .chip_enable_n(chip_enable_n),
        .vin_above_uv_rise(above), .vin_below_uv_fall(below), .vin_over_ov(ov),
        .out_hard_short(hs), .die_over_temp(ot), .det_period(det_period),
        .adc_result(adc_result), .adc_threshold(adc_threshold),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switch_gate_on(gate),
        .test_current_en(tce), .adc_run(adc_run),
        .interrupt_n_o(int_o), .interrupt_n_oe(int_oe));

    ovsw_host_model host (
        .clk(clk), .reg_rdata(reg_rdata), .interrupt_n_o(int_o),
        .interrupt_n_oe(int_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .int_line(int_line));

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd_reg(a, d);
        chk8(d, exp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // hang guard, well above the length of the sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        failures = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        chip_enable_n = 1'b0;
        above = 1'b0;
        below = 1'b1;
        {ov, hs, ot, det_period} = 4'h0;
        adc_result = 8'h10;
        adc_threshold = 8'h80;
        wt(2);
        sys_rst = 1'b0;
        wt(3);
        // reset values, read-only id, unmapped read
        rd_chk(OVSW_ADDR_IDENT, {OVSW_VENDOR_CODE, OVSW_REVISION_CODE});
        host.wr_reg(OVSW_ADDR_IDENT, 8'h00);
        rd_chk(OVSW_ADDR_IDENT, {OVSW_VENDOR_CODE, OVSW_REVISION_CODE});
        rd_chk(OVSW_ADDR_CTRL, 8'h00);
        rd_chk(OVSW_ADDR_STATUS, 8'h00);
        rd_chk(OVSW_ADDR_FLAGS, 8'h00);
        rd_chk(8'h0A, 8'h00);
        $display("test reset done");
        // every control code, the illegal one leaves the last value
        host.wr_reg(OVSW_ADDR_CTRL, 8'hC0);
        rd_chk(OVSW_ADDR_CTRL, 8'hC0);
        host.wr_reg(OVSW_ADDR_CTRL, 8'h40);
        rd_chk(OVSW_ADDR_CTRL, 8'hC0);
        rd_chk(OVSW_ADDR_STATUS, 8'h20);
        // bring the time-out bit back low first, it freezes once detection is off
        det_period = 1'b1;
        host.wr_reg(OVSW_ADDR_CTRL, 8'h00);
        det_period = 1'b0;
        rd_chk(OVSW_ADDR_CTRL, 8'h00);
        host.wr_reg(OVSW_ADDR_CTRL, 8'h40);
        rd_chk(OVSW_ADDR_CTRL, 8'h00);
        host.wr_reg(OVSW_ADDR_CTRL, 8'h80);
        chk1(gate, 1'b0);
        $display("test control done");
        // supply rises: power-on event, then switch on after debounce
        above = 1'b1;
        below = 1'b0;
        wt(20);
        chk1(gate, 1'b1);
        chk1(int_line, 1'b0);
        rd_chk(OVSW_ADDR_STATUS, 8'h90);
        wt(2);
        chk1(int_line, 1'b1);
        host.wr_reg(OVSW_ADDR_CTRL, 8'h80);
        wt(4);
        chk1(gate, 1'b0);
        host.wr_reg(OVSW_ADDR_CTRL, 8'h00);
        chk1(gate, 1'b0);
        wt(20);
        chk1(gate, 1'b1);
        chk1(int_line, 1'b0);
        rd_chk(OVSW_ADDR_STATUS, 8'h90);
        $display("test switch done");
        // overvoltage: flag re-sets while the fault persists
        ov = 1'b1;
        wt(6);
        chk1(gate, 1'b0);
        chk1(int_line, 1'b0);
        rd_chk(OVSW_ADDR_FLAGS, 8'h04);
        rd_chk(OVSW_ADDR_FLAGS, 8'h04);
        ov = 1'b0;
        wt(4);
        rd_chk(OVSW_ADDR_FLAGS, 8'h04);
        rd_chk(OVSW_ADDR_FLAGS, 8'h00);
        wt(20);
        rd_chk(OVSW_ADDR_STATUS, 8'h90);
        // hard short: held off through the restart wait, then retried
        hs = 1'b1;
        wt(3);
        hs = 1'b0;
        wt(5);
        chk1(gate, 1'b0);
        rd_chk(OVSW_ADDR_FLAGS, 8'h02);
        wt(30);
        chk1(gate, 1'b1);
        rd_chk(OVSW_ADDR_STATUS, 8'h90);
        // overtemperature
        ot = 1'b1;
        wt(6);
        chk1(gate, 1'b0);
        ot = 1'b0;
        // let the level leave the synchroniser, or the read sets the flag again
        wt(4);
        rd_chk(OVSW_ADDR_FLAGS, 8'h01);
        wt(20);
        rd_chk(OVSW_ADDR_STATUS, 8'h90);
        $display("test faults done");
        // masked events leave the line released, flag still latched
        host.wr_reg(OVSW_ADDR_MASK, 8'hFF);
        rd_chk(OVSW_ADDR_MASK, OVSW_MASK_USED);
        ov = 1'b1;
        wt(6);
        chk1(int_line, 1'b1);
        ov = 1'b0;
        wt(20);
        chk1(int_line, 1'b1);
        rd_chk(OVSW_ADDR_FLAGS, 8'h04);
        host.wr_reg(OVSW_ADDR_MASK, 8'h00);
        rd_chk(OVSW_ADDR_STATUS, 8'h90);
        rd_chk(OVSW_ADDR_FLAGS, 8'h00);
        wt(2);
        chk1(int_line, 1'b1);
        $display("test mask done");
        // detection below the falling level, current only inside the interval
        host.wr_reg(OVSW_ADDR_CTRL, 8'hC0);
        above = 1'b0;
        below = 1'b1;
        wt(4);
        det_period = 1'b1;
        wt(4);
        chk1(tce, 1'b1);
        chk1(adc_run, 1'b1);
        adc_result = 8'h90;
        wt(3);
        det_period = 1'b0;
        wt(3);
        chk1(tce, 1'b0);
        chk1(int_line, 1'b0);
        rd_chk(OVSW_ADDR_STATUS, 8'h60);
        det_period = 1'b1;
        wt(3);
        chk1(int_line, 1'b1);
        rd_chk(OVSW_ADDR_STATUS, 8'h40);
        // disabled detection stops the source and keeps status frozen
        host.wr_reg(OVSW_ADDR_CTRL, 8'h80);
        wt(3);
        chk1(tce, 1'b0);
        adc_result = 8'h10;
        wt(3);
        rd_chk(OVSW_ADDR_STATUS, 8'h40);
        $display("test detection done");
        // supply returns, then the chip is disabled while the event is pending
        above = 1'b1;
        below = 1'b0;
        wt(4);
        chk1(int_line, 1'b0);
        chip_enable_n = 1'b1;
        wt(6);
        chk1(int_line, 1'b1);
        chk1(gate, 1'b0);
        rd_chk(OVSW_ADDR_STATUS, 8'h40);
        $display("test chip enable done");
        end_of_test();
    end
endmodule
`default_nettype wire
